// ---- logic/mirm_pkg.sv ----
package mirm_pkg;
    localparam logic [7:0] ADDR_GLOBAL_EVENT = 8'h11;
    localparam logic [7:0] ADDR_MAG_FLAGS = 8'h16;
    localparam logic [7:0] ADDR_MAG_AMP_LO = 8'h17;
    localparam logic [7:0] ADDR_MAG_AMP_HI = 8'h18;
    localparam logic [7:0] ADDR_CH2_MODE = 8'h42;
    localparam logic [7:0] ADDR_CH2_TUNE_MODE = 8'h45;
    localparam logic [7:0] ADDR_CH2_TUNE_TGT = 8'h48;
    localparam logic [7:0] ADDR_CH2_EXTRA = 8'h4b;
    localparam logic [7:0] ADDR_UI_EN_FILT = 8'h50;
    localparam logic [7:0] ADDR_MAG_CHARGE = 8'h90;
    localparam logic [7:0] ADDR_MAG_TUNE_TGT = 8'h91;
    localparam logic [7:0] ADDR_MAG_SWITCH = 8'ha0;
    localparam logic [7:0] ADDR_MAG_NEAR_THR = 8'ha1;
    localparam logic [7:0] ADDR_MAG_CLOSE_THR = 8'ha2;
    // Global event bit positions.
    localparam int EV_MAGNET_BIT = 2;
    localparam int EV_BANDED_BIT = 3;
    // Magnet flag bit positions.
    localparam int FL_POLARITY_BIT = 0;
    localparam int FL_NEAR_BIT = 1;
    localparam int FL_CLOSE_BIT = 2;
    // Banded detection enable bit in the UI enable register.
    localparam int UI_BANDED_EN_BIT = 0;
    // Channel 2 mode field: bits 1:0 sensor mode, bits 3:2 receive inputs.
    localparam logic [1:0] MODE_INDUCTIVE = 2'h2;
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [7:0] RST_RESULT = 8'h00;
    localparam int CFG_COUNT = 10;
    typedef enum logic [1:0] {
        mirm_idle_e,
        mirm_capture_e,
        mirm_publish_e
    } mirm_state_e;
endpackage : mirm_pkg

// ---- logic/mirm_conv_if.sv ----
`timescale 1ns/1ps
interface mirm_conv_if;
    logic done;
    logic [15:0] pos_data;
    logic [15:0] neg_data;
    logic [15:0] amplitude;
    logic south;
    logic valid;
    modport src (output done, output pos_data, output neg_data,
                 input amplitude, input south, input valid);
    modport dif (input done, input pos_data, input neg_data,
                 output amplitude, output south, output valid);
endinterface : mirm_conv_if

// ---- logic/mirm_diff.sv ----
`timescale 1ns/1ps
module mirm_diff (
    input wire logic clk,
    input wire logic arst_n,
    mirm_conv_if.dif cv
);
    import mirm_pkg::*;
    logic [15:0] amp;
    logic [15:0] next_amp;
    logic sth;
    logic next_sth;
    logic vld;
    logic next_vld;

    // Positive minus negative channel; polarity from sign.
    always_comb begin
        next_vld = cv.done;
        next_amp = amp;
        next_sth = sth;
        if (cv.done) begin
            if (cv.neg_data > cv.pos_data) begin
                next_amp = cv.neg_data - cv.pos_data;
                next_sth = 1'b1;
            end else begin
                next_amp = cv.pos_data - cv.neg_data;
                next_sth = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            amp <= 16'h0000;
            sth <= 1'b0;
            vld <= 1'b0;
        end else begin
            amp <= next_amp;
            sth <= next_sth;
            vld <= next_vld;
        end
    end

    assign cv.amplitude = amp;
    assign cv.south = sth;
    assign cv.valid = vld;
endmodule : mirm_diff

// ---- logic/mirm_top.sv ----
`timescale 1ns/1ps
module mirm_top (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic mag_conv_done,
    input wire logic [15:0] mag_pos_data,
    input wire logic [15:0] mag_neg_data,
    input wire logic ch2_conv_done,
    input wire logic [15:0] ch2_data,
    input wire logic [15:0] ch2_base,
    output logic [7:0] magnet_charge_cfg,
    output logic [7:0] ch2_mode_cfg
);
    import mirm_pkg::*;

    mirm_conv_if cv ();
    assign cv.done = mag_conv_done;
    assign cv.pos_data = mag_pos_data;
    assign cv.neg_data = mag_neg_data;

    mirm_diff u_diff (
        .clk(clk),
        .arst_n(arst_n),
        .cv(cv.dif)
    );

    logic [7:0] cfg [CFG_COUNT];
    logic [7:0] next_cfg [CFG_COUNT];
    logic [7:0] gev;
    logic [7:0] next_gev;
    logic [7:0] flags;
    logic [7:0] next_flags;
    logic [15:0] amp;
    logic [15:0] next_amp;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic banded_hit;
    logic next_banded_hit;

    function automatic int cfg_index(input logic [7:0] a);
        case (a)
            ADDR_CH2_MODE: cfg_index = 0;
            ADDR_CH2_TUNE_MODE: cfg_index = 1;
            ADDR_CH2_TUNE_TGT: cfg_index = 2;
            ADDR_CH2_EXTRA: cfg_index = 3;
            ADDR_UI_EN_FILT: cfg_index = 4;
            ADDR_MAG_CHARGE: cfg_index = 5;
            ADDR_MAG_TUNE_TGT: cfg_index = 6;
            ADDR_MAG_SWITCH: cfg_index = 7;
            ADDR_MAG_NEAR_THR: cfg_index = 8;
            ADDR_MAG_CLOSE_THR: cfg_index = 9;
            default: cfg_index = -1;
        endcase
    endfunction : cfg_index

    // Amplitudes of 256 or more clear any 8-bit threshold outright, so a
    // strong field never wraps back below a level it has passed.
    function automatic logic reaches(input logic [15:0] a,
        input logic [7:0] thr);
        reaches = a[15:8] != 8'h00 || a[7:0] >= thr;
    endfunction : reaches

    // Writable configuration; writes to read-only or unmapped are ignored.
    always_comb begin
        int idx;
        idx = cfg_index(reg_addr);
        for (int i = 0; i < CFG_COUNT; i++) begin
            next_cfg[i] = cfg[i];
        end
        if (reg_wr && idx >= 0) begin
            next_cfg[idx] = reg_wdata;
        end
    end

    // Thresholds compared against the differential amplitude; both flags
    // and amplitude are taken from the same conversion in one edge.
    always_comb begin
        next_flags = flags;
        next_amp = amp;
        next_gev = gev;
        if (cv.valid) begin
            next_amp = cv.amplitude;
            next_flags = 8'h00;
            next_flags[FL_POLARITY_BIT] = cv.south;
            next_flags[FL_NEAR_BIT] = reaches(cv.amplitude, cfg[8]);
            next_flags[FL_CLOSE_BIT] = reaches(cv.amplitude, cfg[9]);
            if ((next_flags[FL_NEAR_BIT] && !flags[FL_NEAR_BIT]) ||
                (next_flags[FL_CLOSE_BIT] && !flags[FL_CLOSE_BIT])) begin
                next_gev[EV_MAGNET_BIT] = ~gev[EV_MAGNET_BIT];
            end
        end
        // Banded detection is a level that follows channel 2, masked by the UI banded enable bit.
        next_gev[EV_BANDED_BIT] = banded_hit &&
            cfg[4][UI_BANDED_EN_BIT];
    end

    // Channel 2 in inductive mode is the only banded detection source.
    always_comb begin
        next_banded_hit = banded_hit;
        if (ch2_conv_done) begin
            next_banded_hit = cfg[0][1:0] == MODE_INDUCTIVE &&
                ch2_data > ch2_base &&
                (ch2_data - ch2_base) >= {8'h00, cfg[2]};
        end
    end

    always_comb begin
        case (reg_addr)
            ADDR_GLOBAL_EVENT: next_rdata = gev;
            ADDR_MAG_FLAGS: next_rdata = flags;
            ADDR_MAG_AMP_LO: next_rdata = amp[7:0];
            ADDR_MAG_AMP_HI: next_rdata = amp[15:8];
            default: begin
                next_rdata = 8'h00;
                if (cfg_index(reg_addr) >= 0) begin
                    next_rdata = cfg[cfg_index(reg_addr)];
                end
            end
        endcase
        if (!reg_rd) begin
            next_rdata = rdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < CFG_COUNT; i++) begin
                cfg[i] <= RST_CFG;
            end
            gev <= RST_RESULT;
            flags <= RST_RESULT;
            amp <= 16'h0000;
            rdata <= 8'h00;
            banded_hit <= 1'b0;
            magnet_charge_cfg <= RST_CFG;
            ch2_mode_cfg <= RST_CFG;
        end else begin
            cfg <= next_cfg;
            gev <= next_gev;
            flags <= next_flags;
            amp <= next_amp;
            rdata <= next_rdata;
            banded_hit <= next_banded_hit;
            magnet_charge_cfg <= next_cfg[5];
            ch2_mode_cfg <= next_cfg[0];
        end
    end

    assign reg_rdata = rdata;
endmodule : mirm_top

// ---- testbench/mirm_top_assertions.sv ----
`timescale 1ns/1ps
module mirm_top_checker
    import mirm_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] magnet_charge_cfg,
    input wire logic [7:0] ch2_mode_cfg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_charge_copy: assert property (reg_wr && reg_addr == ADDR_MAG_CHARGE
        |=> magnet_charge_cfg == $past(reg_wdata)) else $error("charge cfg");
    a_mode_copy: assert property (reg_wr && reg_addr == ADDR_CH2_MODE
        |=> ch2_mode_cfg == $past(reg_wdata)) else $error("mode cfg");
    a_charge_kept: assert property (
        !(reg_wr && reg_addr == ADDR_MAG_CHARGE) |=> $stable(magnet_charge_cfg))
        else $error("charge cfg moved");
    a_rdata_held: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    a_flags_upper: assert property (reg_rd && reg_addr == ADDR_MAG_FLAGS
        |=> reg_rdata[7:3] == 5'h00) else $error("flag upper bits");
    a_event_unused: assert property (reg_rd && reg_addr == ADDR_GLOBAL_EVENT
        |=> reg_rdata[7:4] == 4'h0) else $error("event upper bits");
    a_charge_read: assert property (reg_rd && !reg_wr
        && reg_addr == ADDR_MAG_CHARGE |=> reg_rdata == magnet_charge_cfg)
        else $error("charge readback");
    a_mode_read: assert property (reg_rd && !reg_wr
        && reg_addr == ADDR_CH2_MODE |=> reg_rdata == ch2_mode_cfg)
        else $error("mode readback");
    c_event_read: cover property (reg_rd && reg_addr == ADDR_GLOBAL_EVENT);
    c_amp_read: cover property (reg_rd && reg_addr == ADDR_MAG_AMP_HI);
    c_cfg_write: cover property (reg_wr && reg_addr == ADDR_MAG_CHARGE);
endmodule : mirm_top_checker

// ---- testbench/mirm_sensor_model.sv ----
`timescale 1ns/1ps
module mirm_sensor_model (
    input wire logic clk,
    output logic mag_conv_done,
    output logic [15:0] mag_pos_data,
    output logic [15:0] mag_neg_data,
    output logic ch2_conv_done,
    output logic [15:0] ch2_data,
    output logic [15:0] ch2_base
);
    initial begin
        {mag_conv_done, ch2_conv_done} = 2'h0;
        {mag_pos_data, mag_neg_data, ch2_data, ch2_base} = 64'h0;
    end
    // Data is inverted once the done pulse ends, so stale values show.
    task automatic mag(input logic [15:0] p, input logic [15:0] n);
        @(negedge clk);
        {mag_pos_data, mag_neg_data, mag_conv_done} = {p, n, 1'b1};
        @(negedge clk);
        {mag_pos_data, mag_neg_data, mag_conv_done} = {~p, ~n, 1'b0};
    endtask : mag
    task automatic ch2(input logic [15:0] d, input logic [15:0] b);
        @(negedge clk);
        {ch2_data, ch2_base, ch2_conv_done} = {d, b, 1'b1};
        @(negedge clk);
        {ch2_data, ch2_base, ch2_conv_done} = {~d, ~b, 1'b0};
    endtask : ch2
endmodule : mirm_sensor_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import mirm_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, md, cc, ad [10];
    logic mcd, ccd;
    logic [15:0] mp, mn, cd, cbs;
    int error_cnt = 0;
    int num_checks = 0;
    always #12.5 clk = ~clk;
    mirm_top i_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .mag_conv_done(mcd), .mag_pos_data(mp),
        .mag_neg_data(mn), .ch2_conv_done(ccd), .ch2_data(cd),
        .ch2_base(cbs), .magnet_charge_cfg(cc), .ch2_mode_cfg(md));
    mirm_sensor_model i_sens (.clk(clk), .mag_conv_done(mcd),
        .mag_pos_data(mp), .mag_neg_data(mn), .ch2_conv_done(ccd),
        .ch2_data(cd), .ch2_base(cbs));
    task automatic close_out;
        if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %0t: %h %h", $time, g, e);
        end
    endtask : cmp
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge clk);
        reg_rd = 1'b0;
        cmp(reg_rdata, e);
    endtask : rd
    initial begin
        ad = '{ADDR_CH2_MODE, ADDR_CH2_TUNE_MODE, ADDR_CH2_TUNE_TGT,
            ADDR_CH2_EXTRA, ADDR_UI_EN_FILT, ADDR_MAG_CHARGE,
            ADDR_MAG_TUNE_TGT, ADDR_MAG_SWITCH, ADDR_MAG_NEAR_THR,
            ADDR_MAG_CLOSE_THR};
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        rd(ADDR_MAG_CHARGE, 8'h00);
        foreach (ad[i]) wr(ad[i], 8'h5a ^ 8'(i));
        cmp(cc, 8'h5f);
        cmp(md, 8'h5a);
        foreach (ad[i]) rd(ad[i], 8'h5a ^ 8'(i));
        wr(ADDR_MAG_FLAGS, 8'hff);
        rd(ADDR_MAG_FLAGS, 8'h00);
        rd(8'h33, 8'h00);
        wr(ADDR_MAG_NEAR_THR, 8'h10);
        wr(ADDR_MAG_CLOSE_THR, 8'h40);
        i_sens.mag(16'h1030, 16'h1000);
        repeat (4) @(negedge clk);
        rd(ADDR_MAG_FLAGS, 8'h02);
        rd(ADDR_MAG_AMP_LO, 8'h30);
        rd(ADDR_MAG_AMP_HI, 8'h00);
        rd(ADDR_GLOBAL_EVENT, 8'h04);
        i_sens.mag(16'h1000, 16'h1234);
        repeat (4) @(negedge clk);
        rd(ADDR_MAG_FLAGS, 8'h07);
        rd(ADDR_MAG_AMP_LO, 8'h34);
        rd(ADDR_MAG_AMP_HI, 8'h02);
        rd(ADDR_GLOBAL_EVENT, 8'h00);
        wr(ADDR_CH2_MODE, 8'h0e);
        cmp(md, 8'h0e);
        wr(ADDR_CH2_TUNE_TGT, 8'h20);
        wr(ADDR_UI_EN_FILT, 8'h01);
        i_sens.ch2(16'h1050, 16'h1000);
        repeat (4) @(negedge clk);
        rd(ADDR_GLOBAL_EVENT, 8'h08);
        wr(ADDR_UI_EN_FILT, 8'h00);
        i_sens.ch2(16'h1050, 16'h1000);
        repeat (4) @(negedge clk);
        rd(ADDR_GLOBAL_EVENT, 8'h00);
        wr(ADDR_CH2_MODE, 8'h0d);
        wr(ADDR_UI_EN_FILT, 8'h01);
        i_sens.ch2(16'h1050, 16'h1000);
        repeat (4) @(negedge clk);
        rd(ADDR_GLOBAL_EVENT, 8'h00);
        close_out();
    end
    initial begin
        #(25 * 4000);
        error_cnt++;
        close_out();
    end
endmodule : tb_top
bind mirm_top mirm_top_checker i_chk (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .magnet_charge_cfg(magnet_charge_cfg), .ch2_mode_cfg(ch2_mode_cfg));
